// >>> core/pioc_top.sv
// Top of the 32-line parallel I/O controller with pin multiplexing and change events.
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/10ps

// Function
// RL1: 32 lines, one bit each per register.
// RL2: Dedicated lines ignore select writes, read owned.
// RL3: Select writes move ownership; status shows owner.
// RL4: Controller-owned line feeds peripheral input zero.
// RL5: Reset: lines 0-24 controller inputs, rest peripheral.
// RL6: Output enable set/clear, status reads back.
// RL7: Stored enable drives pin only when owned.
// RL8: Level set/clear drives owned output, status reads.
// RL9: Owned line without enable is not driven.
// RL10: Peripheral-owned line takes peripheral value and enable.
// RL11: Pin status always returns actual pin level.
// RL12: Filter set/clear, status shows active filters.
// RL13: Filter works under either owner.
// RL14: Irq unmask/mask writes, mask status reads back.
// RL15: Any level change sets event bit.
// RL16: Interrupt output when unmasked event bit set.
// RL17: Event status read returns then clears all.
// RL18: Nonexistent line bits ignore writes, read zero.
// RL19: Bit positions map timers, interrupts, serial ports.
// RL20: Event status cleared by reset.
// RL21: Inputs double-synchronised; filter drops one-cycle pulses.
// RL22: Set and clear act in same write.
module pioc_top (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [pioc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [pioc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [31:0]                 pin_in,
  output logic      [31:0]                 pin_out,
  output logic      [31:0]                 pin_oe,
  input  wire logic [31:0]                 periph_out,
  input  wire logic [31:0]                 periph_oe,
  output logic      [31:0]                 periph_in,
  output logic                             irq
);
  import pioc_pkg::*;

  // ****************************************
  // Functions
  // ****************************************

  // Expands byte enables into a bit mask; lanes without strobe write nothing.
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
    begin
      m[8*i +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  // Returns the write-one vector when the strobe hits the given offset.
  function automatic logic [31:0] hit(input pioc_wr_t w, input logic [7:0] ofs,
                                      input logic [31:0] m);
    return (w.go && (w.addr == ofs)) ? m : ZERO_RST;
  endfunction

  // Applies a write-one set and a write-one clear in the same cycle.
  function automatic logic [31:0] set_clr(input logic [31:0] cur, input logic [31:0] s,
                                          input logic [31:0] c);
    return (cur | s) & ~c;
  endfunction

  // Tells whether a byte address belongs to the register map.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic r;
    r = 1'b0;
    case (a)
      OFS_CSEL_SET, OFS_PSEL_SET, OFS_OWNER,
      OFS_OE_SET, OFS_OE_CLR, OFS_OE_STAT,
      OFS_GF_SET, OFS_GF_CLR, OFS_GF_STAT,
      OFS_LVL_SET, OFS_LVL_CLR, OFS_LVL_STAT, OFS_PIN_STAT,
      OFS_IRQ_UNM, OFS_IRQ_MSK, OFS_MSK_STAT, OFS_EVT_STAT: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  pioc_wr_t    wr;                   // Write strobe from the bus front end.
  pioc_rd_t    rd;                   // Read strobe from the bus front end.
  pioc_rsp_t   rsp;                  // Read data and decode answers.
  logic [31:0] pin_raw;              // Synchronised pin levels.
  logic [31:0] line_lvl;             // Synchronised and optionally filtered levels.
  logic [31:0] wmask;                // Write data gated by strobes and existing lines.

  logic [31:0] owner_r, owner_nxt;   // 1 = controller owns the line.
  logic [31:0] oe_r, oe_nxt;         // Stored output enables.
  logic [31:0] gf_r, gf_nxt;         // Active glitch filters.
  logic [31:0] lvl_r, lvl_nxt;       // Programmed output levels.
  logic [31:0] msk_r, msk_nxt;       // 1 = change interrupt enabled.
  logic [31:0] evt_r, evt_nxt;       // Sticky change events.
  logic [31:0] prev_r, prev_nxt;     // Line level one cycle ago.
  logic [31:0] pout_r, pout_nxt;     // Registered pin output value.
  logic [31:0] poe_r, poe_nxt;       // Registered pin output enable.
  logic [31:0] pin_r, pin_nxt;       // Registered peripheral input.
  logic        irq_r, irq_nxt;       // Registered interrupt output.

  // ****************************************
  // Bus front end and input conditioning
  // ****************************************

  // The bus slave handles all handshakes and hands one strobe per access.
  pioc_axil u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr            (wr),
    .rd            (rd),
    .rsp           (rsp)
  );

  // Every pin is synchronised whatever its owner, so the filter serves both.
  pioc_sync #(
    .W (NLINES)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_i   (pin_in),
    .filt_en (gf_r),
    .raw_o   (pin_raw),
    .line_o  (line_lvl)
  );

  // ****************************************
  // Register file
  // ****************************************

  // Write-one set and clear pairs; a zero bit leaves the state alone.
  always_comb
  begin
    wmask     = wr.data & lane_mask(wr.strb) & LINE_MASK;                      // RL18
    // Dedicated lines stay owned whatever is written.
    owner_nxt = set_clr(owner_r, hit(wr, OFS_CSEL_SET, wmask),
                        hit(wr, OFS_PSEL_SET, wmask)) | DEDICATED;              // RL2 RL3
    oe_nxt    = set_clr(oe_r, hit(wr, OFS_OE_SET, wmask),
                        hit(wr, OFS_OE_CLR, wmask));                            // RL6 RL22
    gf_nxt    = set_clr(gf_r, hit(wr, OFS_GF_SET, wmask),
                        hit(wr, OFS_GF_CLR, wmask));                            // RL12
    // The level is kept even while the line is an input or peripheral-owned.
    lvl_nxt   = set_clr(lvl_r, hit(wr, OFS_LVL_SET, wmask),
                        hit(wr, OFS_LVL_CLR, wmask));                           // RL8
    msk_nxt   = set_clr(msk_r, hit(wr, OFS_IRQ_UNM, wmask),
                        hit(wr, OFS_IRQ_MSK, wmask));                           // RL14
  end

  // Read decode; write-only offsets read zero, unmapped ones answer with an error.
  always_comb
  begin
    rsp.data = ZERO_RST;
    rsp.rerr = ~mapped(rd.addr);
    rsp.werr = ~mapped(wr.addr);
    case (rd.addr)
      OFS_OWNER:    rsp.data = owner_r | DEDICATED;                             // RL2 RL3
      OFS_OE_STAT:  rsp.data = oe_r;                                            // RL6
      OFS_GF_STAT:  rsp.data = gf_r;                                            // RL12
      OFS_LVL_STAT: rsp.data = lvl_r;                                           // RL8
      OFS_PIN_STAT: rsp.data = pin_raw;                                         // RL11
      OFS_MSK_STAT: rsp.data = msk_r;                                           // RL14
      OFS_EVT_STAT: rsp.data = evt_r;                                           // RL17
      default:      rsp.data = ZERO_RST;
    endcase
    rsp.data = rsp.data & LINE_MASK;                                            // RL1 RL18
  end

  // ****************************************
  // Change events and interrupt
  // ****************************************

  // A change in the clearing read cycle still lands, so no event is lost.
  always_comb
  begin
    prev_nxt = line_lvl;
    evt_nxt  = evt_r;
    if (rd.go && (rd.addr == OFS_EVT_STAT))
    begin
      evt_nxt = ZERO_RST;                                                       // RL17
    end
    evt_nxt = evt_nxt | ((line_lvl ^ prev_r) & LINE_MASK);                      // RL15
    // Registered output, so the line follows the events one cycle late.
    irq_nxt = |(evt_r & msk_r);                                                 // RL16
  end

  // ****************************************
  // Pin multiplexer
  // ****************************************

  // Each bit selects between controller and peripheral by its owner bit alone.
  // Bits 0-8 are timer lines, 9-12 interrupt inputs, 13-15 and 20-22 serial.
  always_comb
  begin
    for (int i = 0; i < NLINES; i++)
    begin
      if (owner_r[i])
      begin
        pout_nxt[i] = lvl_r[i];                                                 // RL8
        poe_nxt[i]  = oe_r[i];                                                  // RL7 RL9
        pin_nxt[i]  = 1'b0;                                                     // RL4
      end
      else
      begin
        pout_nxt[i] = periph_out[i];                                            // RL10 RL19
        poe_nxt[i]  = periph_oe[i];                                             // RL10
        pin_nxt[i]  = line_lvl[i];                                              // RL13
      end
    end
  end

  // ****************************************
  // State registers
  // ****************************************

  // Synchronous reset puts lines 0-24 in controller input mode.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      owner_r <= OWNER_RST;                                                     // RL5
      oe_r    <= ZERO_RST;                                                      // RL5
      gf_r    <= ZERO_RST;
      lvl_r   <= ZERO_RST;
      msk_r   <= ZERO_RST;
      evt_r   <= ZERO_RST;                                                      // RL20
      prev_r  <= ZERO_RST;
      pout_r  <= ZERO_RST;
      poe_r   <= ZERO_RST;
      pin_r   <= ZERO_RST;
      irq_r   <= 1'b0;
    end
    else
    begin
      owner_r <= owner_nxt;
      oe_r    <= oe_nxt;
      gf_r    <= gf_nxt;
      lvl_r   <= lvl_nxt;
      msk_r   <= msk_nxt;
      evt_r   <= evt_nxt;
      prev_r  <= prev_nxt;
      pout_r  <= pout_nxt;
      poe_r   <= poe_nxt;
      pin_r   <= pin_nxt;
      irq_r   <= irq_nxt;
    end
  end

  // Outputs come straight from the flops above.
  assign pin_out   = pout_r;
  assign pin_oe    = poe_r;
  assign periph_in = pin_r;
  assign irq       = irq_r;

endmodule // pioc_top

// >>> core/pioc_pkg.sv
// Package with register map, reset values and carriers of the parallel I/O controller.
package pioc_pkg;

  // ****************************************
  // Widths and register offsets
  // ****************************************
  localparam int unsigned NLINES = 32;         // Number of I/O lines.
  localparam int unsigned ADDR_W = 8;          // Byte address width of the map.
  localparam logic [7:0] OFS_CSEL_SET  = 8'h00; // controller_select_set
  localparam logic [7:0] OFS_PSEL_SET  = 8'h04; // peripheral_select_set
  localparam logic [7:0] OFS_OWNER     = 8'h08; // owner_status
  localparam logic [7:0] OFS_OE_SET    = 8'h10; // output_enable_set
  localparam logic [7:0] OFS_OE_CLR    = 8'h14; // output_enable_clear
  localparam logic [7:0] OFS_OE_STAT   = 8'h18; // output_enable_status
  localparam logic [7:0] OFS_GF_SET    = 8'h20; // glitch_filter_set
  localparam logic [7:0] OFS_GF_CLR    = 8'h24; // glitch_filter_clear
  localparam logic [7:0] OFS_GF_STAT   = 8'h28; // glitch_filter_status
  localparam logic [7:0] OFS_LVL_SET   = 8'h30; // output_level_set
  localparam logic [7:0] OFS_LVL_CLR   = 8'h34; // output_level_clear
  localparam logic [7:0] OFS_LVL_STAT  = 8'h38; // output_level_status
  localparam logic [7:0] OFS_PIN_STAT  = 8'h3C; // pin_level_status
  localparam logic [7:0] OFS_IRQ_UNM   = 8'h40; // change_irq_unmask
  localparam logic [7:0] OFS_IRQ_MSK   = 8'h44; // change_irq_mask
  localparam logic [7:0] OFS_MSK_STAT  = 8'h48; // change_irq_mask_status
  localparam logic [7:0] OFS_EVT_STAT  = 8'h4C; // change_event_status

  // ****************************************
  // Reset values and line classes
  // ****************************************
  localparam logic [31:0] OWNER_RST = 32'h01FF_FFFF; // Lines 0..24 controller-owned.
  localparam logic [31:0] DEDICATED = 32'h018F_0000; // Lines 16..19, 23, 24.
  localparam logic [31:0] LINE_MASK = 32'hFFFF_FFFF; // Lines that exist.
  localparam logic [31:0] ZERO_RST  = 32'h0000_0000; // Other registers.
  localparam logic [1:0]  RESP_OKAY   = 2'b00;       // AXI OKAY.
  localparam logic [1:0]  RESP_SLVERR = 2'b10;       // AXI SLVERR.

  // ****************************************
  // Carriers between bus front end and core
  // ****************************************
  typedef struct packed {
    logic              go;   // One-cycle write strobe.
    logic [ADDR_W-1:0] addr; // Byte address.
    logic [31:0]       data; // Write data.
    logic [3:0]        strb; // Byte enables.
  } pioc_wr_t;

  typedef struct packed {
    logic              go;   // One-cycle read strobe.
    logic [ADDR_W-1:0] addr; // Byte address.
  } pioc_rd_t;

  typedef struct packed {
    logic [31:0] data; // Read data for rd.addr.
    logic        rerr; // Read address unmapped.
    logic        werr; // Write address unmapped.
  } pioc_rsp_t;

endpackage

// >>> core/pioc_sync.sv
// Two-stage pin synchroniser with optional one-cycle glitch filter per line.
`timescale 1ns/10ps
module pioc_sync #(
  parameter int unsigned W = 32
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] filt_en,
  output logic      [W-1:0] raw_o,
  output logic      [W-1:0] line_o
);
  import pioc_pkg::*;

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_line
      logic s1_r, s2_r, s3_r, f_r; // Sync stages, delayed copy, filtered level.
      logic f_nxt;                  // Next filtered level.

      // A level is accepted only after two equal samples, so one-cycle pulses die.
      always_comb
      begin
        f_nxt = s2_r;
        if (filt_en[g])
        begin
          f_nxt = (s2_r == s3_r) ? s2_r : f_r; // RL13 RL21
        end
      end

      // The first stage feeds the second stage and nothing else.
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          f_r  <= 1'b0;
        end
        else
        begin
          s1_r <= pin_i[g];    // RL21
          s2_r <= s1_r;
          s3_r <= s2_r;
          f_r  <= f_nxt;
        end
      end

      assign raw_o[g]  = s2_r;
      assign line_o[g] = f_r;
    end
  endgenerate

endmodule // pioc_sync

// >>> core/pioc_axil.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/10ps
module pioc_axil (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [pioc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [pioc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output pioc_pkg::pioc_wr_t             wr,
  output pioc_pkg::pioc_rd_t             rd,
  input  pioc_pkg::pioc_rsp_t            rsp
);
  import pioc_pkg::*;

  logic              awh_r, awh_nxt, wh_r, wh_nxt;   // Address / data held.
  logic              awr_r, awr_nxt, wr_r, wr_nxt;   // Ready flops.
  logic              bv_r, bv_nxt, arh_r, arh_nxt;   // Response / read pending.
  logic              arr_r, arr_nxt, rv_r, rv_nxt;
  logic [ADDR_W-1:0] wa_r, wa_nxt, ra_r, ra_nxt;
  logic [31:0]       wd_r, wd_nxt, rdat_r, rdat_nxt;
  logic [3:0]        ws_r, ws_nxt;
  logic [1:0]        br_r, br_nxt, rr_r, rr_nxt;

  // Address and data are taken in either order; the strobe waits for both.
  always_comb
  begin
    {awh_nxt, wh_nxt, bv_nxt, arh_nxt, rv_nxt} = {awh_r, wh_r, bv_r, arh_r, rv_r};
    {wa_nxt, wd_nxt, ws_nxt, br_nxt} = {wa_r, wd_r, ws_r, br_r};
    {ra_nxt, rdat_nxt, rr_nxt} = {ra_r, rdat_r, rr_r};
    wr = '{go: awh_r & wh_r & ~bv_r, addr: wa_r, data: wd_r, strb: ws_r};
    rd = '{go: arh_r & ~rv_r, addr: ra_r};
    if (s_axi_awvalid && awr_r)
    begin
      awh_nxt = 1'b1;
      wa_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_r)
    begin
      wh_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
    end
    if (wr.go)
    begin
      {awh_nxt, wh_nxt, bv_nxt} = 3'b001;
      br_nxt = rsp.werr ? RESP_SLVERR : RESP_OKAY;
    end
    if (bv_r && s_axi_bready)
    begin
      bv_nxt = 1'b0;
    end
    if (s_axi_arvalid && arr_r)
    begin
      arh_nxt = 1'b1;
      ra_nxt  = s_axi_araddr;
    end
    if (rd.go)
    begin
      {arh_nxt, rv_nxt} = 2'b01;
      rdat_nxt = rsp.data;
      rr_nxt   = rsp.rerr ? RESP_SLVERR : RESP_OKAY;
    end
    if (rv_r && s_axi_rready)
    begin
      rv_nxt = 1'b0;
    end
    // Readies only open while nothing of that kind is in flight.
    awr_nxt = ~awh_nxt & ~bv_nxt;
    wr_nxt  = ~wh_nxt & ~bv_nxt;
    arr_nxt = ~arh_nxt & ~rv_nxt;
  end

  // Registered bus state; readies come up one cycle after reset release.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {awh_r, wh_r, bv_r, arh_r, rv_r} <= 5'b0_0000;
      {awr_r, wr_r, arr_r} <= 3'b000;
      {wa_r, ra_r} <= '0;
      {wd_r, rdat_r, ws_r, br_r, rr_r} <= '0;
    end
    else
    begin
      {awh_r, wh_r, bv_r, arh_r, rv_r} <= {awh_nxt, wh_nxt, bv_nxt, arh_nxt, rv_nxt};
      {awr_r, wr_r, arr_r} <= {awr_nxt, wr_nxt, arr_nxt};
      {wa_r, ra_r} <= {wa_nxt, ra_nxt};
      {wd_r, rdat_r, ws_r, br_r, rr_r} <= {wd_nxt, rdat_nxt, ws_nxt, br_nxt, rr_nxt};
    end
  end

  assign s_axi_awready = awr_r;
  assign s_axi_wready  = wr_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = br_r;
  assign s_axi_arready = arr_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rdat_r;
  assign s_axi_rresp   = rr_r;

endmodule // pioc_axil

// >>> tb/pioc_periph_model.sv
// Model of the on-chip peripherals sharing the multiplexed lines.
`timescale 1ns/10ps
module pioc_periph_model (
  input  wire logic [31:0] val_i,
  input  wire logic [31:0] oe_i,
  input  wire logic        aclk,
  output logic      [31:0] periph_out = 32'h0000_0000,
  output logic      [31:0] periph_oe  = 32'h0000_0000
);
  // Outputs move only after an edge, as a peripheral flop would.
  always @(posedge aclk)
  begin
    periph_out <= val_i;
    periph_oe  <= oe_i;
  end
endmodule // pioc_periph_model

// >>> tb/pioc_top_properties.sv
// Checker of bus answers, reset state and interrupt of the I/O controller.
`timescale 1ns/10ps
module pioc_top_properties
  import pioc_pkg::*;
(
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic [1:0]                  s_axi_bresp,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic [pioc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic [31:0]                 s_axi_rdata,
  input wire logic [1:0]                  s_axi_rresp,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready,
  input wire logic [31:0]                 pin_oe,
  input wire logic [31:0]                 periph_in,
  input wire logic                        irq
);
  logic [7:0] ra_q = 8'h00; // Address of the read under way.
  // Keep the read address, since the answer comes cycles later.
  always @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |-> ##[2:3] s_axi_rvalid) else $error("read answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_reserved_err: assert property ($rose(s_axi_rvalid) && ra_q[3:0] == 4'hC
    && ra_q < 8'h30 |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("reserved read not refused");
  a_ded_zero: assert property ((periph_in & DEDICATED) == 32'h0000_0000)
    else $error("dedicated line fed to peripheral");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !irq
    && pin_oe == 32'h0000_0000 && !s_axi_bvalid) else $error("reset state wrong");
  a_irq_cause: assert property ($fell(irq) |-> $past(s_axi_rvalid) || $past(s_axi_bvalid)
    || $past(s_axi_rvalid, 2) || $past(s_axi_bvalid, 2)) else $error("irq fell alone");
  c_irq: cover property ($rose(irq));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule // pioc_top_properties

bind pioc_top pioc_top_properties i_pioc_top_properties (.*);

// >>> tb/tb_top.sv
// Self-checking bench of the parallel I/O controller.
`timescale 1ns/10ps
module tb_top;
  import pioc_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, irq;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [3:0] s_axi_wstrb = 4'hF; // Whole words only.
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_wdata = 32'h0000_0000, ext = 32'hFFFF_FFFF, pv = 32'hA000_0000;
  logic [31:0] poe = 32'hFE00_0000, s_axi_rdata, pin_out, pin_oe, pin_in, rv;
  logic [31:0] periph_out, periph_oe, periph_in;
  logic [7:0] ra [5] = '{OFS_OWNER, OFS_OE_STAT, OFS_GF_STAT, OFS_LVL_STAT, OFS_MSK_STAT};
  logic [31:0] re [5] = '{OWNER_RST, ZERO_RST, ZERO_RST, ZERO_RST, ZERO_RST};
  int bad_count = 0, cmp_count = 0;
  // Undriven pins take the board level held in ext.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
  always #25 aclk = ~aclk;
  pioc_top i_pioc_top (.*);
  pioc_periph_model i_pioc_periph_model (.val_i(pv), .oe_i(poe), .*);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Write: address and data offered together, each dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      s_axi_bready <= s_axi_bvalid & !s_axi_bready;
    end while (!s_axi_bready);
    rs = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      s_axi_rready <= s_axi_rvalid & !s_axi_rready;
    end while (!s_axi_rready);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, rv, e);
  endtask
  // One-cycle low pulse on line 9, which a filter must swallow.
  task automatic pulse();
    @(posedge aclk);
    ext[9] <= 0;
    @(posedge aclk);
    ext[9] <= 1;
    repeat (8) @(posedge aclk);
  endtask
  task automatic stop_test();
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog: the sequence needs well under 4000 cycles.
  initial
  begin
    #200000;
    bad_count++;
    stop_test();
  end
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    foreach (ra[i]) rc("reset reg", ra[i], re[i]);
    chk("pin_oe", pin_oe, poe);
    chk("pin_out", pin_out, pv);
    chk("periph_in", periph_in, pv);
    rd(OFS_EVT_STAT);
    wr(OFS_PSEL_SET, 32'hFFFF_FFFF);
    rc("owner", OFS_OWNER, DEDICATED);
    wr(OFS_CSEL_SET, 32'h0000_00FF);
    rc("owner", OFS_OWNER, DEDICATED | 32'h0000_00FF);
    chk("periph_in", periph_in, 32'hA070_FF00);
    wr(OFS_OE_SET, 32'h0000_010F);
    wr(OFS_LVL_SET, 32'h0000_0005);
    rc("oe stat", OFS_OE_STAT, 32'h0000_010F);
    rc("lvl stat", OFS_LVL_STAT, 32'h0000_0005);
    chk("pin_oe", pin_oe, poe | 32'h0000_000F);
    chk("pin_out", pin_out, pv | 32'h0000_0005);
    rc("pin lvl", OFS_PIN_STAT, 32'hA1FF_FFF5);
    wr(OFS_OE_CLR, 32'h0000_0001);
    wr(OFS_LVL_CLR, 32'h0000_0004);
    rc("oe stat", OFS_OE_STAT, 32'h0000_010E);
    rc("lvl stat", OFS_LVL_STAT, 32'h0000_0001);
    rc("pin lvl", OFS_PIN_STAT, 32'hA1FF_FFF1);
    rd(OFS_EVT_STAT);
    wr(OFS_IRQ_UNM, 32'h0000_0002);
    rc("mask stat", OFS_MSK_STAT, 32'h0000_0002);
    wr(OFS_LVL_SET, 32'h0000_0002);
    repeat (8) @(posedge aclk);
    chk("irq", 32'(irq), 32'h1);
    rc("events", OFS_EVT_STAT, 32'h0000_0002);
    rc("events", OFS_EVT_STAT, 32'h0000_0000);
    chk("irq", 32'(irq), 32'h0);
    wr(OFS_IRQ_MSK, 32'h0000_0002);
    rc("mask stat", OFS_MSK_STAT, 32'h0000_0000);
    wr(OFS_LVL_CLR, 32'h0000_0002);
    repeat (8) @(posedge aclk);
    chk("irq", 32'(irq), 32'h0);
    rc("rdata", 8'h0C, 32'h0000_0000);
    chk("rresp", 32'(rs), 32'(RESP_SLVERR));
    wr(8'h1C, 32'hFFFF_FFFF);
    chk("bresp", 32'(rs), 32'(RESP_SLVERR));
    rc("events", OFS_EVT_STAT, 32'h0000_0002);
    wr(OFS_GF_SET, 32'h0000_0200);
    rc("filt stat", OFS_GF_STAT, 32'h0000_0200);
    pulse();
    rc("events", OFS_EVT_STAT, 32'h0000_0000);
    wr(OFS_GF_CLR, 32'h0000_0200);
    rc("filt stat", OFS_GF_STAT, 32'h0000_0000);
    pulse();
    rc("events", OFS_EVT_STAT, 32'h0000_0200);
    stop_test();
  end
endmodule // tb_top
